// ==== ilpc_ctrl.v ====
// indicator outputs, link-up output and power-down control of the MAC-PHY
// assumes one 100 MHz clock, synchronous active-low reset, pins outside tristated by oe
//
// Summary of operation
// - primary indicator on, secondary off after reset
// - secondary pin driven only when mux enables
// - function codes 7-10 unavailable in mode 2
// - blink mode defaults to mode 1
// - default functions link+activity and activity only
// - polarity auto, high or low; auto default
// - autosense samples pin level at reset
// - active high drives high, active low sinks
// - mode 1 uses programmed on/off times
// - mode 2 duty follows measured activity
// - link output follows negotiated link-up flag
// - link output active high, polarity bit selectable
// - reset held low: everything tristated, inaccessible
// - soft power-down from strap or control bit
// - ready bit shows soft power-down state
// - soft power-down ignores line, registers accessible
// - clearing request leaves power-down, starts negotiation
// - unstrapped device brings link up alone
// - straps are two-level, latched at reset end
// - strap 0 powers down, 1 stays active
`timescale 1ns/100ps
`default_nettype none
`include "ilpc_defs.vh"

module ilpc_ctrl #(
  parameter integer BLINK_UNIT_CYCLES = `ILPC_BLINK_UNIT_NS / `ILPC_CLK_NS
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [`ILPC_ADDR_W-1:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData,
  // link state from the PHY core, same clock
  input wire negotiatedLinkUp,
  input wire txActivity,
  input wire rxActivity,
  // to the PHY core
  output reg softPowerdown,
  output reg negotiationStart,
  // configuration strap pin
  input wire softPowerdownStrap,
  // primary indicator pin
  input wire indicatorPrimaryIn,
  output reg indicatorPrimaryOut,
  output reg indicatorPrimaryOe,
  // secondary indicator pin
  input wire indicatorSecondaryIn,
  output reg indicatorSecondaryOut,
  output reg indicatorSecondaryOe,
  // link status pin
  output reg linkUpOut,
  output reg linkUpOe
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // a pin that reads high at reset has its load pulled up, so it must sink to light
  function activeLow;
    input [1:0] pol;
    input sensed;
    begin
      case (pol)
        `ILPC_POL_HIGH: activeLow = 1'b0;
        `ILPC_POL_LOW: activeLow = 1'b1;
        default: activeLow = sensed;
      endcase
    end
  endfunction

  // logical on/off state of one indicator
  function indOn;
    input [3:0] fn;
    input mode2;
    input link;
    input act;
    input phase;
    begin
      if (mode2 && fn >= `ILPC_FN_BLINK_ALWAYS && fn <= `ILPC_FN_BLINK_ON_ACT) begin
        indOn = 1'b0;
      end else begin
        case (fn)
          `ILPC_FN_LINK_AND_ACTIVITY: indOn = link & (~act | phase);
          `ILPC_FN_ACTIVITY_ONLY: indOn = act & phase;
          `ILPC_FN_LINK_ONLY: indOn = link;
          `ILPC_FN_ALWAYS_ON: indOn = 1'b1;
          `ILPC_FN_BLINK_ALWAYS: indOn = phase;
          `ILPC_FN_BLINK_ON_LINK: indOn = link & phase;
          `ILPC_FN_BLINK_NO_LINK: indOn = ~link & phase;
          `ILPC_FN_BLINK_ON_ACT: indOn = act & phase;
          default: indOn = 1'b0;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // pin synchronisers: three stages, a change counts once stages two and three agree
  // ----------------------------------------------------------------------------
  reg [2:0] strapSync_reg;
  reg [2:0] priSync_reg;
  reg [2:0] secSync_reg;
  reg strapLvl_reg;
  reg priLvl_reg;
  reg secLvl_reg;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      strapSync_reg <= 3'h0;
      priSync_reg <= 3'h0;
      secSync_reg <= 3'h0;
      strapLvl_reg <= 1'b0;
      priLvl_reg <= 1'b0;
      secLvl_reg <= 1'b0;
    end else begin
      strapSync_reg <= {strapSync_reg[1:0], softPowerdownStrap};
      priSync_reg <= {priSync_reg[1:0], indicatorPrimaryIn};
      secSync_reg <= {secSync_reg[1:0], indicatorSecondaryIn};
      if (strapSync_reg[1] == strapSync_reg[2]) begin
        strapLvl_reg <= strapSync_reg[2];
      end
      if (priSync_reg[1] == priSync_reg[2]) begin
        priLvl_reg <= priSync_reg[2];
      end
      if (secSync_reg[1] == secSync_reg[2]) begin
        secLvl_reg <= secSync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // start-up: pins stay tristated until straps and sense levels are latched
  // ----------------------------------------------------------------------------
  reg [2:0] startCnt_reg;
  reg started_reg;
  reg strapVal_reg;
  reg senseHighPri_reg;
  reg senseHighSec_reg;
  wire latchNow;

  assign latchNow = ~started_reg && (startCnt_reg == `ILPC_STRAP_WAIT);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      startCnt_reg <= 3'h0;
      started_reg <= 1'b0;
      strapVal_reg <= 1'b0;
      senseHighPri_reg <= 1'b0;
      senseHighSec_reg <= 1'b0;
    end else if (!started_reg) begin
      startCnt_reg <= startCnt_reg + 3'h1;
      if (latchNow) begin
        started_reg <= 1'b1;
        strapVal_reg <= strapLvl_reg;
        senseHighPri_reg <= priLvl_reg;
        senseHighSec_reg <= secLvl_reg;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  reg [15:0] control_reg;
  reg [3:0] polarity_reg;
  reg [15:0] priTime_reg;
  reg [15:0] secTime_reg;
  reg [1:0] pinMux_reg;
  reg softPdReq_reg;
  wire [3:0] priFn;
  wire [3:0] secFn;

  assign priFn = control_reg[`ILPC_CTL_PRI_FN];
  assign secFn = control_reg[`ILPC_CTL_SEC_FN];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      control_reg <= `ILPC_CTL_RESET;
      polarity_reg <= {`ILPC_POL_AUTO, `ILPC_POL_AUTO};
      priTime_reg <= `ILPC_TIME_RESET;
      secTime_reg <= `ILPC_TIME_RESET;
      pinMux_reg <= 2'h0;
      softPdReq_reg <= 1'b0;
    end else begin
      if (latchNow) begin
        softPdReq_reg <= ~strapLvl_reg;
      end else if (regWr && regAddr == `ILPC_OFS_POWER) begin
        softPdReq_reg <= regWrData[`ILPC_PWR_REQ];
      end
      if (regWr) begin
        case (regAddr)
          `ILPC_OFS_CONTROL: control_reg <= regWrData & `ILPC_CTL_MASK;
          `ILPC_OFS_POLARITY: polarity_reg <= regWrData[3:0];
          `ILPC_OFS_PRI_TIME: priTime_reg <= regWrData;
          `ILPC_OFS_SEC_TIME: secTime_reg <= regWrData;
          `ILPC_OFS_PIN_MUX: pinMux_reg <= regWrData[1:0];
          default: ;
        endcase
      end
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `ILPC_OFS_CONTROL: regRdData <= control_reg;
        `ILPC_OFS_POLARITY: regRdData <= {12'h000, polarity_reg};
        `ILPC_OFS_PRI_TIME: regRdData <= priTime_reg;
        `ILPC_OFS_SEC_TIME: regRdData <= secTime_reg;
        `ILPC_OFS_PIN_MUX: regRdData <= {14'h0, pinMux_reg};
        `ILPC_OFS_POWER: regRdData <= {10'h000, strapVal_reg, senseHighSec_reg, senseHighPri_reg,
                                       negotiatedLinkUp, softPowerdown, softPdReq_reg};
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // power-down control
  // ----------------------------------------------------------------------------
  // the line side is held quiet until the straps are known, so no link comes up early
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      softPowerdown <= 1'b1;
      negotiationStart <= 1'b0;
    end else begin
      softPowerdown <= ~started_reg | softPdReq_reg;
      // leaving power-down, strapped or by software, kicks off negotiation
      negotiationStart <= started_reg & softPowerdown & ~softPdReq_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // activity measurement for mode 2 and recent-activity flag
  // ----------------------------------------------------------------------------
  reg [31:0] unitCnt_reg;
  reg [`ILPC_ACT_WIN_LOG2-1:0] winCnt_reg;
  reg [`ILPC_ACT_WIN_LOG2-1:0] actCnt_reg;
  reg [3:0] actLevel_reg;
  reg actSeen_reg;
  reg actRecent_reg;
  wire unitTick;
  wire lineAct;

  // activity is only counted while the line is live
  assign lineAct = (txActivity | rxActivity) & ~softPowerdown;
  assign unitTick = (unitCnt_reg == BLINK_UNIT_CYCLES - 1);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      unitCnt_reg <= 32'h0;
      winCnt_reg <= {`ILPC_ACT_WIN_LOG2{1'b0}};
      actCnt_reg <= {`ILPC_ACT_WIN_LOG2{1'b0}};
      actLevel_reg <= 4'h0;
      actSeen_reg <= 1'b0;
      actRecent_reg <= 1'b0;
    end else begin
      unitCnt_reg <= unitTick ? 32'h0 : unitCnt_reg + 32'h1;
      if (unitTick) begin
        // sampling once a unit keeps the counter small; actSeen_reg holds short bursts until the tick
        winCnt_reg <= winCnt_reg + 1'b1;
        actRecent_reg <= actSeen_reg | lineAct;
        actSeen_reg <= 1'b0;
        if (&winCnt_reg) begin
          actLevel_reg <= actCnt_reg[`ILPC_ACT_WIN_LOG2-1 -: 4];
          actCnt_reg <= {`ILPC_ACT_WIN_LOG2{1'b0}};
        end else if (actSeen_reg | lineAct) begin
          actCnt_reg <= actCnt_reg + 1'b1;
        end
      end else if (lineAct) begin
        actSeen_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // blink phase generators
  // ----------------------------------------------------------------------------
  reg [7:0] priPhaseCnt_reg;
  reg priPhase_reg;
  reg [7:0] secPhaseCnt_reg;
  reg secPhase_reg;
  reg [7:0] priLen;
  reg [7:0] secLen;

  always @* begin
    if (control_reg[`ILPC_CTL_PRI_MODE]) begin
      priLen = priPhase_reg ? {4'h0, actLevel_reg} : {4'h0, ~actLevel_reg};
    end else begin
      priLen = priPhase_reg ? priTime_reg[`ILPC_TIME_ON] : priTime_reg[`ILPC_TIME_OFF];
    end
    if (control_reg[`ILPC_CTL_SEC_MODE]) begin
      secLen = secPhase_reg ? {4'h0, actLevel_reg} : {4'h0, ~actLevel_reg};
    end else begin
      secLen = secPhase_reg ? secTime_reg[`ILPC_TIME_ON] : secTime_reg[`ILPC_TIME_OFF];
    end
  end

  // a length of zero still lasts one unit
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      priPhaseCnt_reg <= 8'h00;
      priPhase_reg <= 1'b1;
      secPhaseCnt_reg <= 8'h00;
      secPhase_reg <= 1'b1;
    end else if (unitTick) begin
      if (priPhaseCnt_reg >= priLen) begin
        priPhaseCnt_reg <= 8'h00;
        priPhase_reg <= ~priPhase_reg;
      end else begin
        priPhaseCnt_reg <= priPhaseCnt_reg + 8'h01;
      end
      if (secPhaseCnt_reg >= secLen) begin
        secPhaseCnt_reg <= 8'h00;
        secPhase_reg <= ~secPhase_reg;
      end else begin
        secPhaseCnt_reg <= secPhaseCnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------------
  wire linkLive;
  wire priOn;
  wire secOn;

  assign linkLive = negotiatedLinkUp & ~softPowerdown;
  assign priOn = indOn(priFn, control_reg[`ILPC_CTL_PRI_MODE], linkLive, actRecent_reg, priPhase_reg);
  assign secOn = indOn(secFn, control_reg[`ILPC_CTL_SEC_MODE], linkLive, actRecent_reg, secPhase_reg);

  // reset values keep every pin tristated while rst_n is held low
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      indicatorPrimaryOut <= 1'b0;
      indicatorPrimaryOe <= 1'b0;
      indicatorSecondaryOut <= 1'b0;
      indicatorSecondaryOe <= 1'b0;
      linkUpOut <= 1'b0;
      linkUpOe <= 1'b0;
    end else begin
      indicatorPrimaryOut <= priOn ^ activeLow(polarity_reg[`ILPC_POL_PRI], senseHighPri_reg);
      indicatorPrimaryOe <= started_reg & control_reg[`ILPC_CTL_PRI_EN];
      indicatorSecondaryOut <= secOn ^ activeLow(polarity_reg[`ILPC_POL_SEC], senseHighSec_reg);
      indicatorSecondaryOe <= started_reg & control_reg[`ILPC_CTL_SEC_EN] & pinMux_reg[`ILPC_MUX_SEC_SEL];
      linkUpOut <= linkLive ^ pinMux_reg[`ILPC_MUX_LINK_POL];
      linkUpOe <= started_reg;
    end
  end

endmodule // ilpc_ctrl

`default_nettype wire

// ==== ilpc_defs.vh ====
// constants for the indicator, link-status and power-down control block
// included by ilpc_ctrl.v; holds definitions only
`ifndef ILPC_DEFS_VH
`define ILPC_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------------
`define ILPC_ADDR_W 4
`define ILPC_OFS_CONTROL 4'h0
`define ILPC_OFS_POLARITY 4'h1
`define ILPC_OFS_PRI_TIME 4'h2
`define ILPC_OFS_SEC_TIME 4'h3
`define ILPC_OFS_PIN_MUX 4'h4
`define ILPC_OFS_POWER 4'h5

// ----------------------------------------------------------------------------
// indicator_control fields and reset value
// ----------------------------------------------------------------------------
`define ILPC_CTL_PRI_EN 0
`define ILPC_CTL_PRI_MODE 1
`define ILPC_CTL_PRI_FN 5:2
`define ILPC_CTL_SEC_EN 8
`define ILPC_CTL_SEC_MODE 9
`define ILPC_CTL_SEC_FN 13:10
`define ILPC_CTL_MASK 16'h3F3F
// primary on, mode 1, fn_link_and_activity; secondary off, mode 1, fn_activity_only
`define ILPC_CTL_RESET 16'h0401

// ----------------------------------------------------------------------------
// polarity, blink time, pin mux and power fields
// ----------------------------------------------------------------------------
`define ILPC_POL_PRI 1:0
`define ILPC_POL_SEC 3:2
`define ILPC_POL_AUTO 2'h0
`define ILPC_POL_HIGH 2'h1
`define ILPC_POL_LOW 2'h2
`define ILPC_TIME_OFF 7:0
`define ILPC_TIME_ON 15:8
`define ILPC_TIME_RESET 16'h1010
`define ILPC_MUX_SEC_SEL 0
`define ILPC_MUX_LINK_POL 1
`define ILPC_PWR_REQ 0
`define ILPC_PWR_RDY 1
`define ILPC_PWR_LINK 2
`define ILPC_PWR_SENSE_PRI 3
`define ILPC_PWR_SENSE_SEC 4
`define ILPC_PWR_STRAP 5

// ----------------------------------------------------------------------------
// indicator function codes
// ----------------------------------------------------------------------------
`define ILPC_FN_LINK_AND_ACTIVITY 4'h0
`define ILPC_FN_ACTIVITY_ONLY 4'h1
`define ILPC_FN_LINK_ONLY 4'h2
`define ILPC_FN_ALWAYS_ON 4'h3
`define ILPC_FN_ALWAYS_OFF 4'h4
`define ILPC_FN_BLINK_ALWAYS 4'h7
`define ILPC_FN_BLINK_ON_LINK 4'h8
`define ILPC_FN_BLINK_NO_LINK 4'h9
`define ILPC_FN_BLINK_ON_ACT 4'hA

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ILPC_CLK_NS 10
`define ILPC_BLINK_UNIT_NS 1000000
`define ILPC_STRAP_WAIT 3'h4
`define ILPC_ACT_WIN_LOG2 8

`endif

// ==== ilpc_ctrl_properties.sv ====
// port checker for ilpc_ctrl, bound into every instance
// assumes one clock, synchronous active-low reset; mirrors written registers itself
`timescale 1ns/100ps
`default_nettype none
module ilpc_ctrl_checker #(
  parameter integer BLINK_UNIT_CYCLES = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  // core side
  input wire logic negotiatedLinkUp,
  input wire logic softPowerdown,
  input wire logic negotiationStart,
  // pins
  input wire logic indicatorPrimaryOut,
  input wire logic indicatorPrimaryOe,
  input wire logic indicatorSecondaryOe,
  input wire logic linkUpOut,
  input wire logic linkUpOe
);
  logic [15:0] ctl_reg;
  logic [3:0] pol_reg;
  logic [1:0] mux_reg;
  logic [2:0] upCnt_reg;
  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_reg <= 16'h0401;
      pol_reg <= 4'h0;
      mux_reg <= 2'h0;
      upCnt_reg <= 3'h0;
    end else begin
      if (upCnt_reg != 3'h7) upCnt_reg <= upCnt_reg + 3'h1;
      if (regWr && regAddr == 4'h0) ctl_reg <= regWrData & 16'h3F3F;
      if (regWr && regAddr == 4'h1) pol_reg <= regWrData[3:0];
      if (regWr && regAddr == 4'h4) mux_reg <= regWrData[1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_reset_quiet: assert property ($rose(rst_n) |->
    (!indicatorPrimaryOe && !indicatorSecondaryOe && !linkUpOe && softPowerdown) [*5])
    else $error("pins driven right after reset");
  chk_pri_default: assert property ($rose(rst_n) |-> ##6 indicatorPrimaryOe && !indicatorSecondaryOe)
    else $error("indicator enables wrong after reset");
  chk_sec_mux: assert property (indicatorSecondaryOe |-> $past(mux_reg[0]))
    else $error("secondary driven without mux select");
  chk_mode2_off: assert property ($past(ctl_reg[1]) && $past(pol_reg[1:0]) == 2'h1 &&
    $past(ctl_reg[5:2]) inside {[4'h7:4'hA]} |-> !indicatorPrimaryOut)
    else $error("blink code lit in mode 2");
  chk_pri_polarity: assert property (indicatorPrimaryOe && $past(ctl_reg[5:2]) == 4'h3 &&
    $past(pol_reg[1]) != $past(pol_reg[0]) |-> indicatorPrimaryOut == $past(pol_reg[0]))
    else $error("primary level ignores polarity");
  chk_link_level: assert property (linkUpOe |-> linkUpOut ==
    (($past(negotiatedLinkUp) && !$past(softPowerdown)) ^ $past(mux_reg[1])))
    else $error("link output level wrong");
  chk_pd_entry: assert property (upCnt_reg == 3'h7 && regWr && regAddr == 4'h5 && regWrData[0] |->
    ##[1:2] softPowerdown)
    else $error("power-down request not taken");
  chk_exit_start: assert property ($fell(softPowerdown) |-> ##[0:1] negotiationStart)
    else $error("no negotiation start on leaving power-down");
  chk_start_pulse: assert property (negotiationStart |-> !softPowerdown ##1 !negotiationStart)
    else $error("negotiation start not a single pulse");
  chk_ready_read: assert property (regRd && regAddr == 4'h5 |=> regRdData[1] == $past(softPowerdown))
    else $error("ready bit differs from power-down state");
  cover property ($fell(softPowerdown));
  cover property (indicatorSecondaryOe);
  cover property ($rose(indicatorPrimaryOut));
endmodule // ilpc_ctrl_checker
bind ilpc_ctrl ilpc_ctrl_checker #(.BLINK_UNIT_CYCLES(BLINK_UNIT_CYCLES)) u_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .negotiatedLinkUp(negotiatedLinkUp),
  .softPowerdown(softPowerdown), .negotiationStart(negotiationStart),
  .indicatorPrimaryOut(indicatorPrimaryOut), .indicatorPrimaryOe(indicatorPrimaryOe),
  .indicatorSecondaryOe(indicatorSecondaryOe), .linkUpOut(linkUpOut), .linkUpOe(linkUpOe));
`default_nettype wire

// ==== ilpc_led_model.sv ====
// board model: indicator pins with their resistors and the power-down strap
// assumes the bench picks the strap level while reset is held
`timescale 1ns/100ps
`default_nettype none
module ilpc_led_model (
  // strap choice
  input wire logic strapUp,
  // device pins
  input wire logic priOut,
  input wire logic priOe,
  input wire logic secOut,
  input wire logic secOe,
  // levels seen on the board
  output wire logic priPin,
  output wire logic secPin,
  output wire logic strapPin
);
  // a released pin falls to its resistor, which is what autosense reads
  assign priPin = priOe ? priOut : 1'b1;
  assign secPin = secOe ? secOut : 1'b0;
  // unmanaged boards must pull this up; low only where software will release it
  assign strapPin = strapUp;
endmodule // ilpc_led_model
`default_nettype wire

// ==== ilpc_ctrl_tb.sv ====
// self-checking bench for ilpc_ctrl with the board model
// assumes blink unit shortened to UNIT clocks
`timescale 1ns/100ps
`default_nettype none
module ilpc_ctrl_tb;
  localparam integer UNIT = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic linkUp = 1'b0;
  logic busy = 1'b0;
  logic strapUp = 1'b1;
  wire [15:0] regRdData;
  wire softPowerdown, negotiationStart, priPin, secPin, strapPin;
  wire priOut, priOe, secOut, secOe, linkUpOut, linkUpOe;
  integer fails = 0;
  integer compares = 0;
  integer cycles = 0;
  integer starts = 0;
  integer n, len;
  always #5 clk_sys = ~clk_sys;
  ilpc_ctrl #(.BLINK_UNIT_CYCLES(UNIT)) i_ilpc_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .negotiatedLinkUp(linkUp), .txActivity(busy),
    .rxActivity(busy), .softPowerdown(softPowerdown), .negotiationStart(negotiationStart),
    .softPowerdownStrap(strapPin), .indicatorPrimaryIn(priPin), .indicatorPrimaryOut(priOut),
    .indicatorPrimaryOe(priOe), .indicatorSecondaryIn(secPin), .indicatorSecondaryOut(secOut),
    .indicatorSecondaryOe(secOe), .linkUpOut(linkUpOut), .linkUpOe(linkUpOe));
  ilpc_led_model i_ilpc_led_model (.strapUp(strapUp), .priOut(priOut), .priOe(priOe),
    .secOut(secOut), .secOe(secOe), .priPin(priPin), .secPin(secPin), .strapPin(strapPin));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (negotiationStart === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      conclude;
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input integer k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 check(what, regRdData, exp);
  endtask
  task automatic doReset(input logic v);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    strapUp <= v;
    tick(3);
    check("priOe in reset", priOe, 16'h0);
    check("linkOe in reset", linkUpOe, 16'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(10);
  endtask
  // skips while the primary pin stays at lvl and returns how long that took
  task automatic phaseLen(input logic lvl, output integer k);
    k = 0;
    while (priOut === lvl && k < 200) begin
      tick(1);
      k = k + 1;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    doReset(1'b1);
    check("pd with strap high", softPowerdown, 16'h0);
    check("start pulses", starts[15:0], 16'h1);
    check("priOe", priOe, 16'h1);
    check("secOe", secOe, 16'h0);
    check("linkOe", linkUpOe, 16'h1);
    rdReg(4'h0, 16'h0401, "control");
    rdReg(4'h1, 16'h0000, "polarity");
    rdReg(4'h2, 16'h1010, "pri time");
    rdReg(4'h3, 16'h1010, "sec time");
    rdReg(4'h4, 16'h0000, "pin mux");
    rdReg(4'h5, 16'h0028, "power");
    rdReg(4'h7, 16'h0000, "unmapped");
    @(posedge clk_sys);
    linkUp <= 1'b1;
    tick(3);
    check("link out", linkUpOut, 16'h1);
    wrReg(4'h4, 16'h0002);
    tick(3);
    check("link out inverted", linkUpOut, 16'h0);
    wrReg(4'h4, 16'h0001);
    tick(3);
    check("secOe while disabled", secOe, 16'h0);
    for (n = 0; n < 6; n++) begin
      wrReg(4'h1, 16'(n % 3));
      wrReg(4'h0, n < 3 ? 16'h000D : 16'h0011);
      tick(3);
      check("pri level", priOut, 16'((n < 3) ^ (n % 3 != 1)));
    end
    wrReg(4'h0, 16'h0D01);
    tick(3);
    check("secOe muxed", secOe, 16'h1);
    check("sec level", secOut, 16'h1);
    wrReg(4'h4, 16'h0000);
    tick(3);
    check("secOe unmuxed", secOe, 16'h0);
    wrReg(4'h1, 16'h0001);
    for (n = 7; n < 11; n++) begin
      wrReg(4'h0, 16'(n << 2) | 16'h0003);
      rdReg(4'h0, 16'(n << 2) | 16'h0003, "mode 2 code");
      tick(40);
      check("mode 2 code dark", priOut, 16'h0);
    end
    wrReg(4'h2, 16'h0102);
    wrReg(4'h0, 16'h001D);
    tick(1);
    phaseLen(1'b1, len);
    phaseLen(1'b0, len);
    phaseLen(1'b1, len);
    check("on time", len[15:0], 16'(2 * UNIT));
    phaseLen(1'b0, len);
    check("off time", len[15:0], 16'(3 * UNIT));
    wrReg(4'h0, 16'h0007);
    @(posedge clk_sys);
    busy <= 1'b1;
    len = 0;
    for (n = 0; n < 300; n++) begin
      tick(1);
      len = len + (priOut === 1'b1);
    end
    check("busy blink", 16'(len > 0 && len < 300), 16'h1);
    @(posedge clk_sys);
    busy <= 1'b0;
    wrReg(4'h5, 16'h0001);
    tick(2);
    check("pd entered", softPowerdown, 16'h1);
    rdReg(4'h5, 16'h002F, "power in pd");
    check("link off in pd", linkUpOut, 16'h0);
    n = starts;
    wrReg(4'h5, 16'h0000);
    tick(3);
    check("pd left", softPowerdown, 16'h0);
    check("one start", 16'(starts - n), 16'h1);
    check("link back", linkUpOut, 16'h1);
    wrReg(4'h0, 16'h0009);
    tick(3);
    check("link only lit", priOut, 16'h1);
    doReset(1'b0);
    check("pd with strap low", softPowerdown, 16'h1);
    rdReg(4'h5, 16'h000F, "power strap low");
    wrReg(4'h5, 16'h0000);
    tick(3);
    check("pd released", softPowerdown, 16'h0);
    conclude;
  end
endmodule // ilpc_ctrl_tb
`default_nettype wire
